/* File: rtl/aqs_pkg.sv */
// Shared constants and state types of the air-quality sensor readout.
// Assumes a 25 MHz core clock on both ends of the two-wire link.
package aqs_pkg;
	// Core clock
	localparam int CLK_HZ = 25_000_000;
	// Two-wire link: bit rate and quarter-bit time, rounded up so the rate stays at or below 100 kHz
	localparam int I2C_HZ = 100_000;
	localparam int QTR_CYC = (CLK_HZ + 4 * I2C_HZ - 1) / (4 * I2C_HZ);
	// Device address and the address byte of a read
	localparam logic [6:0] DEV_ADDR = 7'h5a;
	localparam logic [7:0] ADDR_RD = {DEV_ADDR, 1'b1};
	// Pulse width output
	localparam int PWM_HZ = 6500;
	localparam int PWM_CYC = CLK_HZ / PWM_HZ;
	localparam int PPM_LO = 450;
	localparam int PPM_HI = 2000;
	localparam int PPM_SPAN = PPM_HI - PPM_LO;
	// Serial line
	localparam int BAUD = 9600;
	localparam int BIT_CYC = CLK_HZ / BAUD;
	localparam logic [3:0] FRAME_LAST = 4'h9;
	localparam int HDR_LINES = 7;
	// Timing of the data lines and of warm-up, in their own units
	localparam int TICK_S = 1;
	localparam int SEC_CYC = TICK_S * CLK_HZ;
	localparam int BURN_H = 6;
	localparam int BURN_SEC = BURN_H * 3600;
	localparam int RUNIN_MIN = 15;
	localparam int RUNIN_SEC = RUNIN_MIN * 60;
	// Cycles to wait for the synchronised strap before it is captured
	localparam logic [1:0] STRAP_CYC = 2'h3;
	// Character buffer
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 32;
	// Characters
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_HASH = 8'h23;
	// Digit positions: 0 is ten million, 7 is units; the ppm column starts at ten thousand
	localparam logic [2:0] POS_PPM = 3'h3;
	localparam logic [2:0] POS_LAST = 3'h7;
	// Line generator states
	typedef enum logic [2:0] {
		G_IDLE = 3'b000, G_HASH = 3'b001, G_NUM = 3'b010, G_DIG = 3'b011,
		G_SEP = 3'b100, G_CR = 3'b101, G_LF = 3'b110
	} aqs_gen_t;
	// Link slave states
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_ADDR = 3'b001, S_MATCH = 3'b010, S_AACK = 3'b011,
		S_TX = 3'b100, S_RACK = 3'b101
	} aqs_slv_t;
	// Link master states
	typedef enum logic [1:0] {
		M_IDLE = 2'b00, M_START = 2'b01, M_BIT = 2'b10, M_STOP = 2'b11
	} aqs_mst_t;
endpackage

/* File: rtl/aqs_if.sv */
// Two-wire link between the readout device and its single master.
// Assumes pull-ups: a line is low only while some party drives it low.
`timescale 1ns/1ns
interface aqs_if;
	logic mSclOut; // Master clock line level when driven
	logic mSclOeN; // Master drives clock line, low active
	logic mSdaOut; // Master data line level when driven
	logic mSdaOeN; // Master drives data line, low active
	logic dSdaOut; // Device data line level when driven
	logic dSdaOeN; // Device drives data line, low active
	logic scl; // Resolved clock line
	logic sda; // Resolved data line
	// Wired-and with pull-up
	assign scl = !(!mSclOeN && !mSclOut);
	assign sda = !((!mSdaOeN && !mSdaOut) || (!dSdaOeN && !dSdaOut));
	modport master (output mSclOut, output mSclOeN, output mSdaOut, output mSdaOeN,
		input scl, input sda);
	modport device (output dSdaOut, output dSdaOeN, input scl, input sda);
endinterface

/* File: rtl/aqs_device.sv */
// Readout device end: link slave, pulse width output, serial text lines, warm-up.
// Assumes clk is the core clock, linkClk a free clock for the link slave,
// and predPpm/resOhm come from sensing logic on clk.
//
// Overview of operation
// - Slave address 90, read bit appended.
// - Single master, clock line at 100 kHz.
// - Master sends START, read address, awaits ack.
// - Device drives first byte after address ack.
// - Master acks first byte, nacks second, stops.
// - First byte high half, second low half.
// - PWM 6.5 kHz, duty linear 450..2000 ppm.
// - Six-hour burn-in: report 450 ppm, 50% PWM.
// - Burn-in kept nonvolatile; restart runs 15-minute run-in.
// - Serial 9600 baud, 8 data, no parity, 1 stop.
// - Seven header lines, then one line per second.
// - Data line: ppm column, then resistance column.
`timescale 1ns/1ns

module aqs_fifo #(
	parameter int W = 8,
	parameter int D = 32
) (
	input wire logic clk, // Core clock
	input wire logic reset_n, // Async reset, low active
	input wire logic inValid, // Word offered
	output logic inReady, // Room for a word
	input wire logic [W-1:0] inData, // Word in
	output logic outValid, // Word available
	input wire logic outReady, // Drain takes word
	output logic [W-1:0] outData // Oldest word
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D]; // Storage
	logic [AW:0] wrPtr; // Write pointer, wrap bit on top
	logic [AW:0] rdPtr; // Read pointer, wrap bit on top
	// Full when the pointers differ only in the wrap bit
	assign inReady = !(wrPtr[AW] != rdPtr[AW] && wrPtr[AW-1:0] == rdPtr[AW-1:0]);
	assign outValid = wrPtr != rdPtr;
	assign outData = mem[rdPtr[AW-1:0]];
	// Storage write
	always_ff @(posedge clk) begin
		if (inValid && inReady) begin
			mem[wrPtr[AW-1:0]] <= inData;
		end
	end
	// Pointers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			if (inValid && inReady) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (outValid && outReady) begin
				rdPtr <= rdPtr + 1'b1;
			end
		end
	end
endmodule // aqs_fifo

module aqs_device #(
	parameter logic [31:0] SEC_CYC_P = aqs_pkg::SEC_CYC, // Cycles per second
	parameter logic [15:0] BURN_SEC_P = 16'(aqs_pkg::BURN_SEC), // Burn-in seconds
	parameter logic [15:0] RUNIN_SEC_P = 16'(aqs_pkg::RUNIN_SEC) // Run-in seconds
) (
	input wire logic clk, // Core clock
	input wire logic reset_n, // Async reset, low active
	input wire logic linkClk, // Link slave clock
	aqs_if.device bus, // Two-wire link
	input wire logic [15:0] predPpm, // Live prediction
	input wire logic [23:0] resOhm, // Sensor resistance
	input wire logic burnDoneNv, // Stored burn-in flag pin
	output logic burnSaveNv, // Pulse: store burn-in done
	output logic warmUp, // Fixed outputs in force
	output logic pwmOut, // Pulse width output
	output logic txOut // Serial line, idle high
);
	import aqs_pkg::*;

	logic nvMeta, nvSync; // Strap synchroniser
	logic [1:0] strapCnt; // Settling wait
	logic modeKnown; // Strap captured
	logic wasBurned; // Burn-in already done
	logic [31:0] tickCnt; // Second divider
	logic secTick; // One-cycle second pulse
	logic [15:0] secCnt; // Warm-up seconds
	logic warmEnd; // Last warm-up second
	logic [15:0] shownPpm; // Value reported everywhere

	// Strap synchroniser
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			nvMeta <= 1'b0;
			nvSync <= 1'b0;
		end else begin
			nvMeta <= burnDoneNv;
			nvSync <= nvMeta;
		end
	end
	// Capture the stored flag once it has settled after reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strapCnt <= '0;
			modeKnown <= 1'b0;
			wasBurned <= 1'b0;
		end else if (!modeKnown) begin
			if (strapCnt == STRAP_CYC) begin
				modeKnown <= 1'b1;
				wasBurned <= nvSync;
			end else begin
				strapCnt <= strapCnt + 2'h1;
			end
		end
	end
	// Second tick
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tickCnt <= '0;
			secTick <= 1'b0;
		end else if (tickCnt == SEC_CYC_P - 32'h1) begin
			tickCnt <= '0;
			secTick <= 1'b1;
		end else begin
			tickCnt <= tickCnt + 32'h1;
			secTick <= 1'b0;
		end
	end
	// Burn-in on first power-up, short run-in afterwards
	assign warmEnd = modeKnown && warmUp && secTick &&
		secCnt == (wasBurned ? RUNIN_SEC_P : BURN_SEC_P) - 16'h1;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			warmUp <= 1'b1;
			secCnt <= '0;
			burnSaveNv <= 1'b0;
		end else begin
			burnSaveNv <= warmEnd && !wasBurned;
			if (warmEnd) begin
				warmUp <= 1'b0;
			end else if (modeKnown && warmUp && secTick) begin
				secCnt <= secCnt + 16'h1;
			end
		end
	end
	// Fixed 450 ppm while warming up, live value afterwards
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shownPpm <= 16'(PPM_LO);
		end else begin
			shownPpm <= warmUp ? 16'(PPM_LO) : predPpm;
		end
	end

	// Pulse width: compare count*span against offset*period, no divider needed
	logic [11:0] pwmCnt; // Position in period
	logic [15:0] ofs; // Clamped offset above 450 ppm
	logic [23:0] dutyRef; // Threshold, latched per period
	always_comb begin
		if (shownPpm <= 16'(PPM_LO)) begin
			ofs = '0;
		end else if (shownPpm >= 16'(PPM_HI)) begin
			ofs = 16'(PPM_SPAN);
		end else begin
			ofs = shownPpm - 16'(PPM_LO);
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pwmCnt <= '0;
			dutyRef <= '0;
			pwmOut <= 1'b0;
		end else begin
			pwmOut <= 24'(pwmCnt) * 24'(PPM_SPAN) < dutyRef;
			if (pwmCnt == 12'(PWM_CYC - 1)) begin
				pwmCnt <= '0;
				// Latched at the wrap so a period never glitches mid-way
				dutyRef <= warmUp ? 24'(PWM_CYC * PPM_SPAN / 2)
					: 24'(ofs) * 24'(PWM_CYC);
			end else begin
				pwmCnt <= pwmCnt + 12'h1;
			end
		end
	end

	// Text line generator; successive subtraction gives one decimal digit at a time
	aqs_gen_t gst; // Generator state
	logic [2:0] hdrCnt; // Header line number
	logic hdrDone; // All headers sent
	logic [26:0] digVal; // Remainder being printed
	logic [2:0] digPos; // Digit position
	logic [3:0] digAcc; // Digit being counted
	logic inRes; // Printing the resistance column
	logic [23:0] resHold; // Resistance snapshot
	logic genValid; // Character offered
	logic [7:0] genChar; // Character
	logic genReady; // Buffer has room
	logic [26:0] pow; // Weight of current position
	always_comb begin
		unique case (digPos)
			3'h0: pow = 27'h989680;
			3'h1: pow = 27'hf4240;
			3'h2: pow = 27'h186a0;
			3'h3: pow = 27'h2710;
			3'h4: pow = 27'h3e8;
			3'h5: pow = 27'h64;
			3'h6: pow = 27'ha;
			3'h7: pow = 27'h1;
		endcase
	end
	always_comb begin
		genValid = 1'b1;
		genChar = CH_SP;
		unique case (gst)
			G_HASH: genChar = CH_HASH;
			G_NUM: genChar = CH_0 + {5'h0, hdrCnt};
			G_DIG: begin
				genValid = digVal < pow; // Digit final once remainder is below weight
				genChar = CH_0 + {4'h0, digAcc};
			end
			G_SEP: genChar = CH_SP;
			G_CR: genChar = CH_CR;
			G_LF: genChar = CH_LF;
			default: genValid = 1'b0;
		endcase
	end
	// Sequencing; character states advance only when the buffer takes a character
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gst <= G_IDLE;
			hdrCnt <= '0;
			hdrDone <= 1'b0;
			digVal <= '0;
			digPos <= '0;
			digAcc <= '0;
			inRes <= 1'b0;
			resHold <= '0;
		end else begin
			unique case (gst)
				G_IDLE: begin
					if (!hdrDone) begin
						gst <= G_HASH;
					end else if (secTick) begin
						digVal <= 27'(shownPpm);
						resHold <= resOhm;
						digPos <= POS_PPM;
						digAcc <= '0;
						inRes <= 1'b0;
						gst <= G_DIG;
					end
				end
				G_HASH: if (genReady) gst <= G_NUM;
				G_NUM: if (genReady) gst <= G_CR;
				G_DIG: begin
					if (!genValid) begin
						digVal <= digVal - pow;
						digAcc <= digAcc + 4'h1;
					end else if (genReady) begin
						digAcc <= '0;
						if (digPos != POS_LAST) begin
							digPos <= digPos + 3'h1;
						end else begin
							gst <= inRes ? G_CR : G_SEP;
						end
					end
				end
				G_SEP: begin
					if (genReady) begin
						digVal <= 27'(resHold);
						digPos <= '0;
						inRes <= 1'b1;
						gst <= G_DIG;
					end
				end
				G_CR: if (genReady) gst <= G_LF;
				G_LF: begin
					if (genReady) begin
						gst <= G_IDLE;
						if (hdrCnt == 3'(HDR_LINES - 1)) begin
							hdrDone <= 1'b1;
						end else if (!hdrDone) begin
							hdrCnt <= hdrCnt + 3'h1;
						end
					end
				end
				default: gst <= G_IDLE;
			endcase
		end
	end

	// Buffer between generator and transmitter; a slow line stalls the generator
	logic txValid; // Character waiting
	logic txReady; // Transmitter idle
	logic [7:0] txChar; // Next character
	aqs_fifo #(.W(FIFO_W), .D(FIFO_D)) uBuf (
		.clk(clk),
		.reset_n(reset_n),
		.inValid(genValid),
		.inReady(genReady),
		.inData(genChar),
		.outValid(txValid),
		.outReady(txReady),
		.outData(txChar)
	);
	// Transmitter: start, eight data bits LSB first, one stop, no parity
	logic [9:0] txSh; // Frame shifter, bit 0 on line
	logic [11:0] baudCnt; // Bit timer
	logic [3:0] txBit; // Bit in frame
	logic txBusy; // Frame in flight
	assign txReady = !txBusy;
	assign txOut = txSh[0];
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			txSh <= 10'h3ff;
			baudCnt <= '0;
			txBit <= '0;
			txBusy <= 1'b0;
		end else if (!txBusy) begin
			if (txValid) begin
				txSh <= {1'b1, txChar, 1'b0};
				baudCnt <= '0;
				txBit <= '0;
				txBusy <= 1'b1;
			end
		end else if (baudCnt == 12'(BIT_CYC - 1)) begin
			baudCnt <= '0;
			txSh <= {1'b1, txSh[9:1]};
			txBit <= txBit + 4'h1;
			txBusy <= txBit != FRAME_LAST;
		end else begin
			baudCnt <= baudCnt + 12'h1;
		end
	end

	// Word crossing into the link domain by toggle handshake
	logic reqT; // Request toggle, clk side
	logic [15:0] xferWord; // Held stable until acknowledged
	logic ackMeta, ackSync; // Acknowledge synchroniser
	logic reqMeta, reqSync, reqSeen; // Link side request sync
	logic [15:0] linkWord; // Prediction in link domain
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reqT <= 1'b0;
			xferWord <= 16'(PPM_LO);
			ackMeta <= 1'b0;
			ackSync <= 1'b0;
		end else begin
			ackMeta <= reqSeen;
			ackSync <= ackMeta;
			if (reqT == ackSync) begin
				xferWord <= shownPpm;
				reqT <= !reqT;
			end
		end
	end
	always_ff @(posedge linkClk or negedge reset_n) begin
		if (!reset_n) begin
			reqMeta <= 1'b0;
			reqSync <= 1'b0;
			reqSeen <= 1'b0;
			linkWord <= 16'(PPM_LO);
		end else begin
			reqMeta <= reqT;
			reqSync <= reqMeta;
			reqSeen <= reqSync;
			if (reqSync != reqSeen) begin
				linkWord <= xferWord;
			end
		end
	end

	// Link slave on linkClk; line levels synchronised before use
	logic sclMeta, sclSync, sclPrev; // Clock line sync
	logic sdaMeta, sdaSync, sdaPrev; // Data line sync
	logic sclRise, sclFall, startSeen, stopSeen; // Line events
	aqs_slv_t sst; // Slave state
	logic [2:0] bitCnt; // Bit in byte
	logic [7:0] rxSh; // Address shifter
	logic [7:0] txByteSh; // Data shifter
	logic [15:0] txWord; // Snapshot for one read
	logic lowByte; // Second byte in flight
	logic mAck; // Master acknowledged
	logic sdaLow; // Pull data line low
	assign sclRise = sclSync && !sclPrev;
	assign sclFall = !sclSync && sclPrev;
	assign startSeen = sclSync && sclPrev && sdaPrev && !sdaSync;
	assign stopSeen = sclSync && sclPrev && !sdaPrev && sdaSync;
	assign bus.dSdaOut = 1'b0;
	assign bus.dSdaOeN = !sdaLow;
	always_ff @(posedge linkClk or negedge reset_n) begin
		if (!reset_n) begin
			{sclMeta, sclSync, sclPrev} <= 3'h7;
			{sdaMeta, sdaSync, sdaPrev} <= 3'h7;
		end else begin
			{sclMeta, sclSync, sclPrev} <= {bus.scl, sclMeta, sclSync};
			{sdaMeta, sdaSync, sdaPrev} <= {bus.sda, sdaMeta, sdaSync};
		end
	end
	always_ff @(posedge linkClk or negedge reset_n) begin
		if (!reset_n) begin
			sst <= S_IDLE;
			bitCnt <= '0;
			rxSh <= '0;
			txByteSh <= '0;
			txWord <= '0;
			lowByte <= 1'b0;
			mAck <= 1'b0;
			sdaLow <= 1'b0;
		end else if (stopSeen) begin
			sst <= S_IDLE;
			sdaLow <= 1'b0;
		end else if (startSeen) begin
			sst <= S_ADDR;
			bitCnt <= '0;
			sdaLow <= 1'b0;
		end else begin
			unique case (sst)
				S_IDLE: sdaLow <= 1'b0;
				S_ADDR: begin
					if (sclRise) begin
						rxSh <= {rxSh[6:0], sdaSync};
						bitCnt <= bitCnt + 3'h1;
						if (bitCnt == 3'h7) sst <= S_MATCH;
					end
				end
				S_MATCH: begin
					if (sclFall) begin
						// Writes and other addresses are left unanswered
						if (rxSh == ADDR_RD) begin
							sdaLow <= 1'b1;
							txWord <= linkWord; // Both bytes from one value
							sst <= S_AACK;
						end else begin
							sst <= S_IDLE;
						end
					end
				end
				S_AACK: begin
					if (sclFall) begin
						sdaLow <= !txWord[15];
						txByteSh <= {txWord[14:8], 1'b0};
						bitCnt <= '0;
						lowByte <= 1'b0;
						sst <= S_TX;
					end
				end
				S_TX: begin
					if (sclFall) begin
						if (bitCnt == 3'h7) begin
							sdaLow <= 1'b0;
							sst <= S_RACK;
						end else begin
							sdaLow <= !txByteSh[7];
							txByteSh <= {txByteSh[6:0], 1'b0};
							bitCnt <= bitCnt + 3'h1;
						end
					end
				end
				S_RACK: begin
					if (sclRise) begin
						mAck <= !sdaSync;
					end else if (sclFall) begin
						if (mAck && !lowByte) begin
							sdaLow <= !txWord[7];
							txByteSh <= {txWord[6:0], 1'b0};
							bitCnt <= '0;
							lowByte <= 1'b1;
							sst <= S_TX;
						end else begin
							sst <= S_IDLE;
						end
					end
				end
				default: sst <= S_IDLE;
			endcase
		end
	end
endmodule // aqs_device

/* File: rtl/aqs_master.sv */
// Master end of the two-wire link: reads the two-byte prediction on request.
// Assumes the core clock clk; the link clock is divided from it and driven out.
`timescale 1ns/1ns
module aqs_master (
	input wire logic clk, // Core clock
	input wire logic reset_n, // Async reset, low active
	aqs_if.master bus, // Two-wire link
	input wire logic reqValid, // Read request
	output logic reqReady, // Idle, request taken
	output logic resValid, // Pulse: result ready
	output logic [15:0] resData, // Prediction in ppm
	output logic resNack // Device did not answer
);
	import aqs_pkg::*;

	aqs_mst_t mst; // Master state
	logic [5:0] qCnt; // Quarter-bit timer
	logic qTick; // End of a quarter
	logic [1:0] ph; // Quarter within bit
	logic [4:0] bitIdx; // Bit of the 27-bit transfer
	logic [15:0] rxWord; // Collected data
	logic nack; // Address not acknowledged
	logic sclLow, sdaLow; // Pull lines low
	logic sdaMeta, sdaSync; // Data line sync
	logic drv; // Level wanted on data line

	assign reqReady = mst == M_IDLE;
	assign qTick = qCnt == 6'(QTR_CYC - 1);
	assign bus.mSclOut = 1'b0;
	assign bus.mSdaOut = 1'b0;
	assign bus.mSclOeN = !sclLow;
	assign bus.mSdaOeN = !sdaLow;
	// Bits 0..7 address, 8 device ack, 9..16 high byte, 17 our ack,
	// 18..25 low byte, 26 our nack
	always_comb begin
		if (bitIdx < 5'h8) begin
			drv = ADDR_RD[~bitIdx[2:0]];
		end else if (bitIdx == 5'h11) begin
			drv = 1'b0;
		end else begin
			drv = 1'b1; // Released: device drives or nack
		end
	end
	// Data line synchroniser
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sdaMeta <= 1'b1;
			sdaSync <= 1'b1;
		end else begin
			sdaMeta <= bus.sda;
			sdaSync <= sdaMeta;
		end
	end
	// Quarter timer, restarted by each request
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			qCnt <= '0;
		end else if (mst == M_IDLE || qTick) begin
			qCnt <= '0;
		end else begin
			qCnt <= qCnt + 6'h1;
		end
	end
	// Transfer sequencing
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mst <= M_IDLE;
			ph <= '0;
			bitIdx <= '0;
			rxWord <= '0;
			nack <= 1'b0;
			sclLow <= 1'b0;
			sdaLow <= 1'b0;
			resValid <= 1'b0;
			resData <= '0;
			resNack <= 1'b0;
		end else begin
			resValid <= 1'b0;
			unique case (mst)
				M_IDLE: begin
					if (reqValid) begin
						sdaLow <= 1'b1; // Start: data falls, clock high
						nack <= 1'b0;
						mst <= M_START;
					end
				end
				M_START: begin
					if (qTick) begin
						sclLow <= 1'b1;
						ph <= '0;
						bitIdx <= '0;
						mst <= M_BIT;
					end
				end
				M_BIT: begin
					if (qTick) begin
						ph <= ph + 2'h1;
						unique case (ph)
							2'h0: sdaLow <= !drv;
							2'h1: sclLow <= 1'b0;
							2'h2: begin
								if (bitIdx == 5'h8) begin
									nack <= sdaSync;
								end else if (bitIdx != 5'h11 && bitIdx != 5'h1a) begin
									rxWord <= {rxWord[14:0], sdaSync}; // High byte first
								end
							end
							2'h3: begin
								sclLow <= 1'b1;
								if (bitIdx == 5'h1a || (bitIdx == 5'h8 && nack)) begin
									mst <= M_STOP;
									ph <= '0;
								end else begin
									bitIdx <= bitIdx + 5'h1;
								end
							end
						endcase
					end
				end
				M_STOP: begin
					if (qTick) begin
						ph <= ph + 2'h1;
						unique case (ph)
							2'h0: sdaLow <= 1'b1;
							2'h1: sclLow <= 1'b0;
							2'h2: begin
								sdaLow <= 1'b0; // Stop: data rises, clock high
								resValid <= 1'b1;
								resData <= rxWord;
								resNack <= nack;
								mst <= M_IDLE;
							end
							2'h3: mst <= M_IDLE;
						endcase
					end
				end
			endcase
		end
	end
endmodule // aqs_master

/* File: sim/aqs_link_monitor.sv */
// Checker of the two-wire link between master and device ends.
// Assumes the link signals of aqs_if and the core clock domain.
`timescale 1ns/1ns
module aqs_link_monitor (
	input wire logic clk, // Core clock
	input wire logic reset_n, // Async reset, low active
	input wire logic mSclOut, // Master clock level
	input wire logic mSclOeN, // Master clock enable
	input wire logic mSdaOut, // Master data level
	input wire logic mSdaOeN, // Master data enable
	input wire logic dSdaOut, // Device data level
	input wire logic dSdaOeN, // Device data enable
	input wire logic scl, // Resolved clock line
	input wire logic sda // Resolved data line
);
	logic sclD, sdaD; // Line levels one cycle back
	logic [4:0] cnt; // Clock rises since start
	logic [7:0] sh; // Bits seen on rises
	logic [11:0] per; // Cycles since last rise, saturating
	logic rise; // Clock line rose
	assign rise = !sclD && scl;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Delayed lines
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sclD <= 1'b1;
			sdaD <= 1'b1;
		end else begin
			sclD <= scl;
			sdaD <= sda;
		end
	end
	// Bit count restarts on every start condition
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 5'h00;
			sh <= 8'h00;
		end else if (sclD && scl && sdaD && !sda) begin
			cnt <= 5'h00;
		end else if (rise) begin
			cnt <= cnt + 5'h01;
			sh <= {sh[6:0], sda};
		end
	end
	// Saturates so the first rise after reset passes
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) per <= 12'hfff;
		else if (rise) per <= 12'h000;
		else if (per != 12'hfff) per <= per + 12'h001;
	end
	drive_low_a: assert property (!mSclOut && !mSdaOut && !dSdaOut)
		else $error("Driven level not low");
	// Device stays off the data line until the whole address byte is in
	addr_quiet_a: assert property (cnt < 5'h08 |-> dSdaOeN)
		else $error("Device drove data during address");
	no_clash_a: assert property (mSdaOeN || dSdaOeN)
		else $error("Both ends drive data");
	dev_hold_a: assert property (sclD && scl |-> $stable(dSdaOeN))
		else $error("Device data moved in clock high");
	scl_high_a: assert property (rise |-> scl [*8])
		else $error("Clock high too short");
	scl_rate_a: assert property (rise |-> per >= 12'h0f9)
		else $error("Clock above rate");
	addr_ack_a: assert property (rise && cnt == 5'h08 && sh == 8'hb5 |-> !dSdaOeN)
		else $error("Address not acked");
	data_ack_a: assert property (rise && cnt == 5'h11 |-> !sda)
		else $error("First byte not acked");
	last_nack_a: assert property (rise && cnt == 5'h1a |-> sda)
		else $error("Second byte acked");
endmodule // aqs_link_monitor

/* File: sim/tb.sv */
// Bench: master and device ends joined over aqs_if, reads and warm-up.
// Assumes short seconds through the device parameters.
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
	$display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb;
	import aqs_pkg::*;
	localparam int S = 5000; // Short second
	logic clk, linkClk, reset_n, reqValid, reqReady, resValid, resNack;
	logic burnDoneNv, burnSaveNv, warmUp, pwmOut, txOut;
	logic [15:0] predPpm, resData;
	logic [23:0] resOhm;
	logic [7:0] ch;
	int bad_count = 0, cmp_count = 0, hi, lo;
	aqs_if aqs_if_inst();
	aqs_device #(.SEC_CYC_P(32'(S)), .BURN_SEC_P(16'h0003), .RUNIN_SEC_P(16'h0002))
		aqs_device_inst(.clk(clk), .reset_n(reset_n), .linkClk(linkClk), .bus(aqs_if_inst),
		.predPpm(predPpm), .resOhm(resOhm), .burnDoneNv(burnDoneNv), .burnSaveNv(burnSaveNv),
		.warmUp(warmUp), .pwmOut(pwmOut), .txOut(txOut));
	aqs_master aqs_master_inst(.clk(clk), .reset_n(reset_n), .bus(aqs_if_inst),
		.reqValid(reqValid), .reqReady(reqReady), .resValid(resValid), .resData(resData),
		.resNack(resNack));
	aqs_link_monitor aqs_link_monitor_inst(.clk(clk), .reset_n(reset_n),
		.mSclOut(aqs_if_inst.mSclOut), .mSclOeN(aqs_if_inst.mSclOeN),
		.mSdaOut(aqs_if_inst.mSdaOut), .mSdaOeN(aqs_if_inst.mSdaOeN),
		.dSdaOut(aqs_if_inst.dSdaOut), .dSdaOeN(aqs_if_inst.dSdaOeN),
		.scl(aqs_if_inst.scl), .sda(aqs_if_inst.sda));
	// Clocks, link clock offset in phase
	initial begin clk = 1'b0; forever #20 clk = ~clk; end
	initial begin linkClk = 1'b0; #3; forever #6 linkClk = ~linkClk; end
	task results;
		if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// One read through the master user port
	task rd(input logic [15:0] e);
		int k;
		@(posedge clk) reqValid <= 1'b1;
		@(posedge clk) reqValid <= 1'b0;
		k = 0;
		while (resValid !== 1'b1 && k < 9000) begin @(negedge clk); k++; end
		`CHK(resValid, 1'b1)
		`CHK(resNack, 1'b0)
		`CHK(resData, e)
		`CHK(reqReady, 1'b1)
	endtask
	// One whole pulse: high and low counts
	task pw;
		hi = 0;
		lo = 0;
		while (pwmOut !== 1'b0) @(negedge clk);
		while (pwmOut !== 1'b1) @(negedge clk);
		while (pwmOut === 1'b1) begin hi++; @(negedge clk); end
		while (pwmOut !== 1'b1) begin lo++; @(negedge clk); end
	endtask
	// Warm-up length in seconds, then the store pulse
	task wu(input int secs, input logic save);
		int n;
		n = 0;
		while (warmUp !== 1'b0) begin n++; @(negedge clk); end
		`CHK(n / S, secs)
		// Store pulse stands in the very cycle in which warm-up ends
		`CHK(burnSaveNv, save)
	endtask
	// Main sequence
	initial begin
		reset_n = 1'b0; reqValid = 1'b0; burnDoneNv = 1'b0;
		predPpm = 16'h05dc; resOhm = 24'h01e240;
		repeat (20) @(posedge clk);
		`CHK(warmUp, 1'b1)
		reset_n <= 1'b1;
		fork
			begin
				while (txOut !== 1'b0) @(negedge clk);
				repeat (BIT_CYC / 2) @(negedge clk);
				`CHK(txOut, 1'b0)
				for (int i = 0; i < 8; i++) begin repeat (BIT_CYC) @(negedge clk); ch[i] = txOut; end
				`CHK(ch, 8'h23)
				repeat (BIT_CYC) @(negedge clk);
				`CHK(txOut, 1'b1)
			end
			begin
				pw();
				`CHK(hi, 1923)
				rd(16'h01c2);
			end
			wu(3, 1'b1);
		join
		rd(16'h05dc);
		pw();
		`CHK(hi, 2606)
		`CHK(hi + lo, PWM_CYC)
		// Restart with burn-in already stored
		burnDoneNv <= 1'b1;
		reset_n <= 1'b0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		fork
			rd(16'h01c2);
			wu(2, 1'b0);
		join
		results();
	end
	// Watchdog well above the expected run of about 48500 cycles
	initial begin
		repeat (70000) @(posedge clk);
		bad_count++;
		results();
	end
endmodule // tb
